// ==== core/drt_top.v ====
// dram refresh timer: control registers, prescaled counter, compare match and refresh request
`timescale 1ns/1ns
`include "drt_map.vh"

module drt_top (
  // clock and reset
  input  wire                    clk,
  input  wire                    rstn,
  // register port
  input  wire [`DRT_ADDR_W-1:0]  reg_addr,
  input  wire [`DRT_DATA_W-1:0]  reg_wdata,
  input  wire [1:0]              reg_size,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [`DRT_RDATA_W-1:0] reg_rdata,
  // refresh request towards the dram cycle logic
  output reg                     refresh_req,
  input  wire                    refresh_ack,
  output wire                    refresh_active_sel,
  output wire                    refresh_kind_sel,
  output wire [2:0]              refresh_wait_cycles,
  // interrupts
  output wire                    match_irq,
  output wire                    irq
);

  // refresh control register
  reg                      act_q;
  reg                      kind_q;
  reg  [1:0]               wait_q;
  // timer control/status register
  reg                      flag_q;
  reg                      flag_d;
  reg                      ie_q;
  reg  [2:0]               ps_q;
  reg                      arm_q;
  reg                      arm_d;
  // counter and compare value
  reg  [`DRT_CNT_W-1:0]    cnt_q;
  reg  [`DRT_CNT_W-1:0]    cnt_d;
  reg  [`DRT_CNT_W-1:0]    cmp_q;
  reg                      eq_prev_q;
  // interrupt status and mask
  reg  [`DRT_EV_W-1:0]     ist_q;
  reg  [`DRT_EV_W-1:0]     ist_d;
  reg  [`DRT_EV_W-1:0]     imk_q;
  reg                      req_d;
  reg  [`DRT_RDATA_W-1:0]  rdata_d;

  // decode
  wire [`DRT_ADDR_W-1:0]   wadr;
  wire [2:0]               wr_ix;
  wire [2:0]               rd_ix0;
  wire [2:0]               rd_ix1;
  wire                     rd_long;
  wire                     size_ok;
  wire                     wr_ok;
  wire                     wr_bad;
  wire                     wr_ctrl;
  wire                     wr_tcs;
  wire                     wr_cnt;
  wire                     wr_cmp;
  wire                     wr_imk;
  wire                     rd_tcs;
  wire                     rd_ist;
  wire [`DRT_DATA_W-1:0]   rd_word0;
  // timer
  wire                     tick;
  wire                     eq_now;
  wire                     match_evt;
  wire                     refr_evt;
  wire [`DRT_EV_W-1:0]     ev;

  // map a halfword byte address onto a register index
  // anything unmapped falls to the none index and so never reaches a register
  function [2:0] idx_of;
    input [`DRT_ADDR_W-1:0] a;
    begin
      case (a)
        `DRT_CTRL_ADDR: idx_of = `DRT_IX_CTRL;
        `DRT_TCS_ADDR:  idx_of = `DRT_IX_TCS;
        `DRT_CNT_ADDR:  idx_of = `DRT_IX_CNT;
        `DRT_CMP_ADDR:  idx_of = `DRT_IX_CMP;
        `DRT_IST_ADDR:  idx_of = `DRT_IX_IST;
        `DRT_IMK_ADDR:  idx_of = `DRT_IX_IMK;
        default:        idx_of = `DRT_IX_NONE;
      endcase
    end
  endfunction

  // read view of one register, unused upper bits zero
  // reserved bits cannot show stale data since they are never stored
  function [`DRT_DATA_W-1:0] word_of;
    input [2:0] ix;
    begin
      word_of = {`DRT_DATA_W{1'b0}};
      case (ix)
        `DRT_IX_CTRL: begin
          word_of[`DRT_CTRL_ACT]                  = act_q;
          word_of[`DRT_CTRL_KIND]                 = kind_q;
          word_of[`DRT_CTRL_WT_HI:`DRT_CTRL_WT_LO] = wait_q;
        end
        `DRT_IX_TCS: begin
          word_of[`DRT_TCS_FLAG]                 = flag_q;
          word_of[`DRT_TCS_IE]                   = ie_q;
          word_of[`DRT_TCS_PS_HI:`DRT_TCS_PS_LO] = ps_q;
        end
        `DRT_IX_CNT: word_of[`DRT_CNT_W-1:0] = cnt_q;
        `DRT_IX_CMP: word_of[`DRT_CNT_W-1:0] = cmp_q;
        `DRT_IX_IST: word_of[`DRT_EV_W-1:0]  = ist_q;
        `DRT_IX_IMK: word_of[`DRT_EV_W-1:0]  = imk_q;
        default:     word_of = {`DRT_DATA_W{1'b0}};
      endcase
    end
  endfunction

  // writes count only as sixteen-bit accesses on an even address
  // a refused write to a mapped register still raises the bad-write event
  assign size_ok = (reg_size == `DRT_SZ_WORD) && !reg_addr[0];
  assign wr_ix   = idx_of(reg_addr);
  assign wr_ok   = reg_wr && size_ok && (wr_ix != `DRT_IX_NONE);
  assign wadr    = {reg_addr[`DRT_ADDR_W-1:1], 1'b0};
  assign wr_bad  = reg_wr && !size_ok && (idx_of(wadr) != `DRT_IX_NONE);
  assign wr_ctrl = wr_ok && (wr_ix == `DRT_IX_CTRL);
  assign wr_tcs  = wr_ok && (wr_ix == `DRT_IX_TCS);
  assign wr_cnt  = wr_ok && (wr_ix == `DRT_IX_CNT);
  assign wr_cmp  = wr_ok && (wr_ix == `DRT_IX_CMP);
  assign wr_imk  = wr_ok && (wr_ix == `DRT_IX_IMK);

  // long reads cover two halfwords and must be four-byte aligned
  // a misaligned long read returns zero rather than a torn pair of halves
  assign rd_long = (reg_size == `DRT_SZ_LONG);
  assign rd_ix0  = rd_long ? ((reg_addr[1:0] == 2'h0) ? idx_of(reg_addr) : `DRT_IX_NONE)
                           : idx_of(wadr);
  assign rd_ix1  = (rd_long && reg_addr[1:0] == 2'h0) ? idx_of(reg_addr + `DRT_WORD_STEP)
                                                      : `DRT_IX_NONE;

  // read side effects see every size that covers the register
  // so a long read of the control pair arms the flag clear just like a word read
  assign rd_tcs = reg_rd && (rd_ix0 == `DRT_IX_TCS || rd_ix1 == `DRT_IX_TCS);
  assign rd_ist = reg_rd && (rd_ix0 == `DRT_IX_IST || rd_ix1 == `DRT_IX_IST);

  // halfword seen by byte and word reads
  assign rd_word0 = word_of(rd_ix0);

  // refresh control register, fields above bit 7 read zero
  // kind and wait only steer the dram cycle logic; the enable also gates the refresh request raised here
  always @(posedge clk) begin
    if (!rstn) begin
      act_q  <= 1'b0;
      kind_q <= 1'b0;
      wait_q <= `DRT_WAIT_RST;
    end else if (wr_ctrl) begin
      act_q  <= reg_wdata[`DRT_CTRL_ACT];
      kind_q <= reg_wdata[`DRT_CTRL_KIND];
      wait_q <= reg_wdata[`DRT_CTRL_WT_HI:`DRT_CTRL_WT_LO];
    end
  end

  assign refresh_active_sel  = act_q;
  assign refresh_kind_sel    = kind_q;
  // code 0 to 3 means one to four wait cycles
  assign refresh_wait_cycles = {1'b0, wait_q} + `DRT_WAIT_BASE;

  // prescaled count clock
  // the divider restarts from zero whenever the select goes back to off
  drt_prescaler u_presc (
    .clk  (clk),
    .rstn (rstn),
    .sel  (ps_q),
    .tick (tick)
  );

  // match is taken on the edge into equality so a held count flags only once
  // trade-off: writing a compare equal to the held count also flags once
  assign eq_now    = (cnt_q == cmp_q);
  assign match_evt = eq_now && !eq_prev_q;

  // history resets low; count and compare differ out of reset, so no false match
  always @(posedge clk) begin
    if (!rstn) begin
      eq_prev_q <= 1'b0;
    end else begin
      eq_prev_q <= eq_now;
    end
  end

  // counter: software write wins over a tick, a tick after a match restarts from zero
  // limitation: a tick that lands on a software write is lost
  always @* begin
    cnt_d = cnt_q;
    if (wr_cnt) begin
      cnt_d = reg_wdata[`DRT_CNT_W-1:0];
    end else if (tick) begin
      if (eq_now) begin
        cnt_d = `DRT_CNT_RST;
      end else begin
        cnt_d = cnt_q + `DRT_CNT_STEP;
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= `DRT_CNT_RST;
      cmp_q <= `DRT_CMP_RST;
    end else begin
      cnt_q <= cnt_d;
      if (wr_cmp) begin
        cmp_q <= reg_wdata[`DRT_CNT_W-1:0];
      end
    end
  end

  // flag clear needs a prior read of the flag as one; any write to the register disarms
  // the arm bit keeps a blind zero write from losing a match software never saw
  always @* begin
    arm_d  = arm_q;
    flag_d = flag_q;
    if (rd_tcs && flag_q) begin
      arm_d = 1'b1;
    end
    if (wr_tcs) begin
      arm_d = 1'b0;
      if (arm_q && !reg_wdata[`DRT_TCS_FLAG]) begin
        flag_d = 1'b0;
      end
    end
    // a match in the clearing cycle is not lost
    if (match_evt) begin
      flag_d = 1'b1;
    end
  end

  // timer control/status register
  // writing one to the flag bit does nothing; only a match sets it
  always @(posedge clk) begin
    if (!rstn) begin
      flag_q <= 1'b0;
      arm_q  <= 1'b0;
      ie_q   <= 1'b0;
      ps_q   <= `DRT_PS_RST;
    end else begin
      flag_q <= flag_d;
      arm_q  <= arm_d;
      if (wr_tcs) begin
        ie_q <= reg_wdata[`DRT_TCS_IE];
        ps_q <= reg_wdata[`DRT_TCS_PS_HI:`DRT_TCS_PS_LO];
      end
    end
  end

  // level request, follows flag and enable with no extra delay
  assign match_irq = flag_q && ie_q;

  // refresh request holds until acknowledged; matches while pending merge into it
  // merging spares the dram side a burst of back-to-back stale requests
  assign refr_evt = match_evt && act_q;

  always @* begin
    req_d = refresh_req;
    if (refresh_ack) begin
      req_d = 1'b0;
    end
    if (refr_evt) begin
      req_d = 1'b1;
    end
    // turning refresh off withdraws a request not yet served
    if (!act_q) begin
      req_d = 1'b0;
    end
  end

  // registered so the dram cycle logic sees a glitch-free request
  always @(posedge clk) begin
    if (!rstn) begin
      refresh_req <= 1'b0;
    end else begin
      refresh_req <= req_d;
    end
  end

  // sticky event bits, cleared by reading them, a new event beats the read
  // so an event in the reading cycle is never lost to software
  assign ev[`DRT_EV_MATCH] = match_evt;
  assign ev[`DRT_EV_REFR]  = refr_evt;
  assign ev[`DRT_EV_BADW]  = wr_bad;

  always @* begin
    ist_d = ist_q;
    if (rd_ist) begin
      ist_d = `DRT_EV_RST;
    end
    ist_d = ist_d | ev;
  end

  always @(posedge clk) begin
    if (!rstn) begin
      ist_q <= `DRT_EV_RST;
      imk_q <= `DRT_EV_RST;
    end else begin
      ist_q <= ist_d;
      if (wr_imk) begin
        imk_q <= reg_wdata[`DRT_EV_W-1:0];
      end
    end
  end

  // level interrupt, high while any unmasked status bit is set
  assign irq = |(ist_q & imk_q);

  // read data: byte from big-endian halfword, word, or two halfwords for long
  // the mux settles within the strobe cycle and the register below holds the answer
  always @* begin
    rdata_d = {`DRT_RDATA_W{1'b0}};
    if (reg_rd) begin
      case (reg_size)
        `DRT_SZ_BYTE: begin
          if (reg_addr[0]) begin
            rdata_d[`DRT_BYTE_W-1:0] = rd_word0[`DRT_BYTE_W-1:0];
          end else begin
            rdata_d[`DRT_BYTE_W-1:0] = rd_word0[`DRT_DATA_W-1:`DRT_BYTE_W];
          end
        end
        `DRT_SZ_WORD: begin
          rdata_d[`DRT_DATA_W-1:0] = word_of(rd_ix0);
        end
        `DRT_SZ_LONG: begin
          rdata_d = {word_of(rd_ix0), word_of(rd_ix1)};
        end
        default: begin
          rdata_d = {`DRT_RDATA_W{1'b0}};
        end
      endcase
    end
  end

  // read data stand one cycle after the strobe and are zero otherwise
  always @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= {`DRT_RDATA_W{1'b0}};
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule // drt_top

// ==== core/drt_map.vh ====
// register map, field layout, reset values and constants of the dram refresh timer
// Overview of operation
// - refresh enable low: no refresh requests, counter runs as plain interval timer
// - two-bit wait field gives one to four wait cycles, resets to zero
// - match flag goes high when counter equals compare value, low after reset
// - flag clears only by reading it as one, then writing zero to it
// - interrupt enable high lets the set match flag drive the match interrupt
// - prescaler field: zero stops counting, others pick clock over 2 to 4096
// - eight-bit readable, writable up-counter steps on each prescaled tick, resets zero
// - eight-bit readable, writable compare value resets to all ones
// - any read size is accepted; only sixteen-bit writes take effect
`ifndef DRT_MAP_VH
`define DRT_MAP_VH

// widths
`define DRT_ADDR_W      32
`define DRT_DATA_W      16
`define DRT_RDATA_W     32
`define DRT_CNT_W       8
`define DRT_BYTE_W      8
`define DRT_DIV_W       12
`define DRT_EV_W        3

// register byte addresses, big-endian halfwords
`define DRT_CTRL_ADDR   32'h05FFFFAC
`define DRT_TCS_ADDR    32'h05FFFFAE
`define DRT_CNT_ADDR    32'h05FFFFB0
`define DRT_CMP_ADDR    32'h05FFFFB2
`define DRT_IST_ADDR    32'h05FFFFB4
`define DRT_IMK_ADDR    32'h05FFFFB6
`define DRT_WORD_STEP   32'h00000002

// register indices
`define DRT_IX_CTRL     3'h0
`define DRT_IX_TCS      3'h1
`define DRT_IX_CNT      3'h2
`define DRT_IX_CMP      3'h3
`define DRT_IX_IST      3'h4
`define DRT_IX_IMK      3'h5
`define DRT_IX_NONE     3'h7

// access sizes
`define DRT_SZ_BYTE     2'h0
`define DRT_SZ_WORD     2'h1
`define DRT_SZ_LONG     2'h2

// refresh control fields
`define DRT_CTRL_ACT    7
`define DRT_CTRL_KIND   6
`define DRT_CTRL_WT_HI  5
`define DRT_CTRL_WT_LO  4

// timer control/status fields
`define DRT_TCS_FLAG    7
`define DRT_TCS_IE      6
`define DRT_TCS_PS_HI   5
`define DRT_TCS_PS_LO   3

// interrupt status and mask bits
`define DRT_EV_MATCH    0
`define DRT_EV_REFR     1
`define DRT_EV_BADW     2

// reset values
`define DRT_CNT_RST     8'h00
`define DRT_CMP_RST     8'hFF
`define DRT_WAIT_RST    2'h0
`define DRT_PS_RST      3'h0
`define DRT_EV_RST      3'h0
`define DRT_CNT_STEP    8'h01
`define DRT_WAIT_BASE   3'h1

// prescaler selections and divider masks
`define DRT_PS_OFF      3'h0
`define DRT_PS_D2       3'h1
`define DRT_PS_D8       3'h2
`define DRT_PS_D32      3'h3
`define DRT_PS_D128     3'h4
`define DRT_PS_D512     3'h5
`define DRT_PS_D2048    3'h6
`define DRT_PS_D4096    3'h7
`define DRT_MSK_D2      12'h001
`define DRT_MSK_D8      12'h007
`define DRT_MSK_D32     12'h01F
`define DRT_MSK_D128    12'h07F
`define DRT_MSK_D512    12'h1FF
`define DRT_MSK_D2048   12'h7FF
`define DRT_MSK_D4096   12'hFFF
`define DRT_DIV_STEP    12'h001
`define DRT_DIV_RST     12'h000

`endif

// ==== core/drt_prescaler.v ====
// clock prescaler giving one-cycle count ticks at the selected division
`timescale 1ns/1ns
`include "drt_map.vh"

module drt_prescaler (
  // clock and reset
  input  wire       clk,
  input  wire       rstn,
  // division select, zero stops
  input  wire [2:0] sel,
  // one-cycle tick per divided period
  output wire       tick
);

  reg  [`DRT_DIV_W-1:0] div_q;
  reg  [`DRT_DIV_W-1:0] mask;

  // divider is held at zero while stopped so a restart begins a full period
  always @(posedge clk) begin
    if (!rstn || sel == `DRT_PS_OFF) begin
      div_q <= `DRT_DIV_RST;
    end else begin
      div_q <= div_q + `DRT_DIV_STEP;
    end
  end

  // a change of select mid-period may give one short first period
  always @* begin
    case (sel)
      `DRT_PS_D2:    mask = `DRT_MSK_D2;
      `DRT_PS_D8:    mask = `DRT_MSK_D8;
      `DRT_PS_D32:   mask = `DRT_MSK_D32;
      `DRT_PS_D128:  mask = `DRT_MSK_D128;
      `DRT_PS_D512:  mask = `DRT_MSK_D512;
      `DRT_PS_D2048: mask = `DRT_MSK_D2048;
      `DRT_PS_D4096: mask = `DRT_MSK_D4096;
      default:       mask = `DRT_DIV_RST;
    endcase
  end

  // tick on the last cycle of each divided period
  assign tick = (sel != `DRT_PS_OFF) && ((div_q & mask) == mask);

endmodule // drt_prescaler

// ==== tb/drt_checker.sv ====
// port assertions for the dram refresh timer
`timescale 1ns/1ns
module drt_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // refresh side
  input wire logic        refresh_req,
  input wire logic        refresh_ack,
  input wire logic        refresh_active_sel,
  input wire logic [2:0]  refresh_wait_cycles,
  // interrupts
  input wire logic        match_irq,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // read data shows only in the cycle after a read
  property p_rdata_idle; $past(rstn) && !$past(reg_rd) |-> reg_rdata == 32'h00000000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
  // control outputs move only on a register write
  property p_wait_stable; $past(rstn) && !$past(reg_wr) |-> $stable(refresh_wait_cycles); endproperty
  a_wait_stable: assert property (p_wait_stable) else $error("wait cycles changed without write");
  property p_act_stable; $past(rstn) && !$past(reg_wr) |-> $stable(refresh_active_sel); endproperty
  a_act_stable: assert property (p_act_stable) else $error("refresh enable changed without write");
  property p_wait_range; refresh_wait_cycles inside {[3'h1:3'h4]}; endproperty
  a_wait_range: assert property (p_wait_range) else $error("wait cycles out of range");
  // no request may be raised while refresh is off
  property p_req_needs_act; !refresh_active_sel |=> !refresh_req; endproperty
  a_req_needs_act: assert property (p_req_needs_act) else $error("request while refresh off");
  // one request pending at a time: acknowledged request is withdrawn, unanswered one holds
  property p_ack_drop; refresh_req && refresh_ack |=> !refresh_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
  property p_req_hold; refresh_req && !refresh_ack && refresh_active_sel |=> refresh_req; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped unanswered");
  // the flag, and so the match interrupt, is cleared only by a write
  property p_flag_hold; $past(rstn) && $past(match_irq) && !$past(reg_wr) |-> match_irq; endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("match interrupt fell without write");
  property p_irq_fall; $past(rstn) && $fell(irq) |-> $past(reg_rd) || $past(reg_wr); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
endmodule // drt_checker

// ==== tb/drt_dram_model.sv ====
// behavioural dram side answering refresh requests
`timescale 1ns/1ns
module drt_dram_model (
  // clock and reset
  input  wire       clk,
  input  wire       rstn,
  // refresh handshake
  input  wire       refresh_req,
  input  wire       refresh_kind_sel,
  input  wire [2:0] refresh_wait_cycles,
  input  wire       slow,
  output reg        refresh_ack,
  output integer    n_refr
);
  reg  [3:0] wait_q;
  wire [3:0] lim;

  // self refresh spends one fixed wait cycle, cbr spends the wait cycles; slow adds 4
  assign lim = (refresh_kind_sel ? 4'h1 : {1'b0, refresh_wait_cycles}) + (slow ? 4'h4 : 4'h0);
  // one-cycle ack; holding ack off while answering avoids a double count
  always @(posedge clk) begin
    if (!rstn) begin
      wait_q <= 4'h0;
      refresh_ack <= 1'b0;
      n_refr <= 0;
    end else if (refresh_req && !refresh_ack) begin
      if (wait_q == lim) begin
        refresh_ack <= 1'b1;
        wait_q <= 4'h0;
        n_refr <= n_refr + 1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else begin
      refresh_ack <= 1'b0;
    end
  end
endmodule // drt_dram_model

// ==== tb/dram_refresh_timer_tb_top.sv ====
// self-checking bench for the dram refresh timer
`timescale 1ns/1ns
`include "drt_map.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module dram_refresh_timer_tb_top;
  reg         clk, rstn, reg_wr, reg_rd, slow;
  reg  [31:0] reg_addr;
  reg  [15:0] reg_wdata;
  reg  [1:0]  reg_size;
  wire [31:0] reg_rdata;
  wire        refresh_req, refresh_ack, refresh_active_sel, refresh_kind_sel, match_irq, irq;
  wire [2:0]  refresh_wait_cycles;
  integer     n_refr, failures, n_tests, cyc, i, tick_cnt;
  integer     dv [1:7] = '{2, 8, 32, 128, 512, 2048, 4096};

  drt_top u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_size(reg_size),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .refresh_req(refresh_req),
    .refresh_ack(refresh_ack), .refresh_active_sel(refresh_active_sel), .refresh_kind_sel(refresh_kind_sel),
    .refresh_wait_cycles(refresh_wait_cycles), .match_irq(match_irq), .irq(irq));
  drt_dram_model u_dram (.clk(clk), .rstn(rstn), .refresh_req(refresh_req), .refresh_kind_sel(refresh_kind_sel),
    .refresh_wait_cycles(refresh_wait_cycles), .slow(slow), .refresh_ack(refresh_ack), .n_refr(n_refr));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, well above the prescaler sweep
  initial tick_cnt = 0;
  always @(posedge clk) begin
    tick_cnt++;
    if (tick_cnt == 40000) begin
      failures++;
      tally_and_finish;
    end
  end

  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task wr(input [31:0] a, input [15:0] d, input [1:0] s);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      reg_size <= s;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  // data is looked at in its single answer cycle
  task rd(input [31:0] a, input [1:0] s, input [31:0] e);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      reg_size <= s;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
    end
  endtask

  initial begin
    {rstn, reg_wr, reg_rd, slow, reg_addr, reg_wdata} = 0;
    reg_size = `DRT_SZ_WORD;
    failures = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // reset values
    rd(`DRT_CTRL_ADDR, `DRT_SZ_WORD, 32'h00000000);
    rd(`DRT_TCS_ADDR, `DRT_SZ_WORD, 32'h00000000);
    rd(`DRT_CNT_ADDR, `DRT_SZ_WORD, 32'h00000000);
    rd(`DRT_CMP_ADDR, `DRT_SZ_WORD, 32'h000000FF);
    `CHK(refresh_wait_cycles, 3'h1)
    // every wait code, both refresh kinds
    for (i = 0; i < 4; i++) begin
      wr(`DRT_CTRL_ADDR, {9'h000, i[0], i[1:0], 4'h0}, `DRT_SZ_WORD);
      `CHK(refresh_wait_cycles, i[2:0] + 3'h1)
      `CHK(refresh_kind_sel, i[0])
    end
    // byte write refused, flagged as bad write; status clears on read
    wr(`DRT_CMP_ADDR, 16'h0011, `DRT_SZ_BYTE);
    rd(`DRT_CMP_ADDR, `DRT_SZ_WORD, 32'h000000FF);
    rd(`DRT_IST_ADDR, `DRT_SZ_WORD, 32'h00000004);
    rd(`DRT_IST_ADDR, `DRT_SZ_WORD, 32'h00000000);
    wr(`DRT_TCS_ADDR, 16'h0040, `DRT_SZ_WORD);
    rd(`DRT_CTRL_ADDR, `DRT_SZ_LONG, 32'h00700040);
    rd(`DRT_CMP_ADDR + 32'h1, `DRT_SZ_BYTE, 32'h000000FF);
    rd(`DRT_CMP_ADDR, `DRT_SZ_BYTE, 32'h00000000);
    rd(32'h05FFFFB8, `DRT_SZ_WORD, 32'h00000000);
    // stopped counter holds a written value
    wr(`DRT_CNT_ADDR, 16'h0005, `DRT_SZ_WORD);
    repeat (20) @(posedge clk);
    rd(`DRT_CNT_ADDR, `DRT_SZ_WORD, 32'h00000005);
    // one tick per divisor: read between the first and second tick
    for (i = 1; i < 8; i++) begin
      wr(`DRT_CNT_ADDR, 16'h0000, `DRT_SZ_WORD);
      wr(`DRT_TCS_ADDR, {10'h001, i[2:0], 3'h0}, `DRT_SZ_WORD);
      repeat (dv[i] * 3 / 2 - 1) @(posedge clk);
      rd(`DRT_CNT_ADDR, `DRT_SZ_WORD, 32'h00000001);
      wr(`DRT_TCS_ADDR, 16'h0040, `DRT_SZ_WORD);
    end
    // match with refresh off: flag and interrupt, no request; stop before a second match
    wr(`DRT_CMP_ADDR, 16'h0003, `DRT_SZ_WORD);
    wr(`DRT_CNT_ADDR, 16'h0000, `DRT_SZ_WORD);
    wr(`DRT_TCS_ADDR, 16'h0048, `DRT_SZ_WORD);
    repeat (9) @(posedge clk);
    #1;
    `CHK(match_irq, 1'b1)
    `CHK(refresh_req, 1'b0)
    // zero written without a prior read leaves the flag
    wr(`DRT_TCS_ADDR, 16'h0040, `DRT_SZ_WORD);
    rd(`DRT_TCS_ADDR, `DRT_SZ_WORD, 32'h000000C0);
    wr(`DRT_TCS_ADDR, 16'h0040, `DRT_SZ_WORD);
    rd(`DRT_TCS_ADDR, `DRT_SZ_WORD, 32'h00000040);
    `CHK(match_irq, 1'b0)
    // refresh on, interrupt enable off, slow dram side
    slow <= 1'b1;
    wr(`DRT_CTRL_ADDR, 16'h0080, `DRT_SZ_WORD);
    `CHK(refresh_active_sel, 1'b1)
    wr(`DRT_CNT_ADDR, 16'h0000, `DRT_SZ_WORD);
    wr(`DRT_TCS_ADDR, 16'h0008, `DRT_SZ_WORD);
    cyc = 0;
    while (n_refr < 2 && cyc < 100) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    `CHK(n_refr, 2)
    `CHK(match_irq, 1'b0)
    wr(`DRT_TCS_ADDR, 16'h0000, `DRT_SZ_WORD);
    `CHK(irq, 1'b0)
    wr(`DRT_IMK_ADDR, 16'h0003, `DRT_SZ_WORD);
    `CHK(irq, 1'b1)
    rd(`DRT_IST_ADDR, `DRT_SZ_WORD, 32'h00000003);
    `CHK(irq, 1'b0)
    tally_and_finish;
  end
endmodule // dram_refresh_timer_tb_top

bind drt_top drt_checker u_chk (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .refresh_req(refresh_req), .refresh_ack(refresh_ack), .refresh_active_sel(refresh_active_sel),
  .refresh_wait_cycles(refresh_wait_cycles), .match_irq(match_irq), .irq(irq));
